// File: rtl/otp_access_pkg.sv
package otp_access_pkg;
	// register offsets on the byte-wide register port
	localparam logic [7:0] OFS_ROM_ACCESS_CONTROL = 8'h2d;
	localparam logic [7:0] OFS_ROM_POINTER_HIGH = 8'h2e;
	localparam logic [7:0] OFS_ROM_POINTER_LOW = 8'h2f;
	localparam logic [7:0] OFS_ROM_DATA_HIGH = 8'h30;
	localparam logic [7:0] OFS_ROM_DATA_LOW = 8'h31;
	localparam logic [7:0] OFS_ROM_COMMAND = 8'h32;

	// control register field positions
	localparam int BIT_READ_PERMIT = 0;
	localparam int BIT_WRITE_PERMIT = 1;
	localparam int BIT_PUMP_ENABLE = 2;
	localparam int BIT_VOLTAGE_OK = 3;
	localparam int BIT_DETECT_ENABLE = 4;
	localparam int BIT_REGION_SELECT = 6;
	localparam int BIT_CONTROL_ONE = 7;

	// command register fields (write) and status fields (read)
	localparam int BIT_CMD_READ = 0;
	localparam int BIT_CMD_PROGRAM = 1;
	localparam int BIT_STAT_BUSY = 0;
	localparam int BIT_STAT_REFUSED = 4;
	localparam int BIT_STAT_RANGE = 5;

	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h80;
	localparam logic [5:0] RST_POINTER_HIGH = 6'h00;
	localparam logic [7:0] RST_POINTER_LOW = 8'h00;
	localparam logic [15:0] RST_WORD_VALUE = 16'h0000;
	localparam logic [15:0] BLANK_WORD = 16'hffff;

	// array geometry
	localparam int POINTER_WIDTH = 14;
	localparam int INFO_WORDS = 64;
	localparam logic [POINTER_WIDTH-1:0] INFO_LAST = 14'h003f;
	localparam int MAIN_TAIL_WORDS = 1024;
	localparam logic [3:0] TAIL_TOP_8K = 4'h7;
	localparam logic [3:0] TAIL_TOP_16K = 4'hf;
	localparam int INDEX_WIDTH = 11;
	localparam logic [INDEX_WIDTH-1:0] INFO_BASE = 11'h400;

	// timing
	localparam longint CLOCK_HZ = 20000000;
	localparam longint PROG_TIME_MS = 500;
	localparam int PROG_CYCLES = int'((PROG_TIME_MS * CLOCK_HZ) / 1000);

	typedef enum {idle, reading, programming} access_state_t;

	// one request from the access unit to the word store
	typedef struct packed {
		logic read_en;
		logic prog_en;
		logic [INDEX_WIDTH-1:0] index;
		logic [15:0] word;
	} store_req_t;
endpackage : otp_access_pkg

// File: rtl/otp_data_region_access.sv
`timescale 1ns/1ns
`default_nettype none
module otp_data_region_access #(
	parameter int PROG_WAIT = otp_access_pkg::PROG_CYCLES,
	parameter bit MAIN_IS_16K = 1'b0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic supply_above_threshold,
	input wire logic display_pump_enable,
	output logic prog_pump_on,
	output logic voltage_detect_on,
	output logic program_pulse_on,
	output logic display_supply_internal
);
	import otp_access_pkg::*;

	localparam int COUNT_WIDTH = $clog2(PROG_WAIT + 1);
	localparam logic [COUNT_WIDTH-1:0] WAIT_LAST = COUNT_WIDTH'(PROG_WAIT - 1);

	////////////////////////////////////////////////////////////////
	// helpers

	// pointer to flat store index; valid clear when pointer is outside the region
	function automatic logic [INDEX_WIDTH:0] map_pointer(
		input logic region,
		input logic [POINTER_WIDTH-1:0] pointer,
		input logic big_part
	);
		logic [3:0] top;
		logic [INDEX_WIDTH:0] result;
		top = big_part ? TAIL_TOP_16K : TAIL_TOP_8K;
		result = '0;
		if (!region) begin
			if (pointer <= INFO_LAST) begin
				result = {1'b1, INFO_BASE | INDEX_WIDTH'(pointer[5:0])};
			end
		end else if (pointer[13:10] == top) begin
			result = {1'b1, 1'b0, pointer[9:0]};
		end
		return result;
	endfunction : map_pointer

	function automatic logic is_write(
		input logic strobe,
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		return strobe && (addr == offset);
	endfunction : is_write

	////////////////////////////////////////////////////////////////
	// declarations

	logic region_select;
	logic voltage_detect_enable;
	logic prog_pump_enable;
	logic write_permit;
	logic read_permit;
	logic prog_voltage_ok;
	logic [POINTER_WIDTH-1:0] rom_word_pointer;
	logic [15:0] rom_word_value;
	logic busy;
	logic read_landing;
	logic refused;
	logic range_error;
	logic supply_meta;
	logic supply_sync;
	access_state_t state;
	access_state_t next_state;
	logic [COUNT_WIDTH-1:0] wait_count;
	store_req_t req;
	store_req_t next_req;
	logic [15:0] store_word;
	logic [INDEX_WIDTH:0] mapped;
	logic in_range;
	logic cmd_read;
	logic cmd_program;
	logic start_read;
	logic start_program;
	logic program_refused;
	logic [7:0] control_view;
	logic [7:0] status_view;

	////////////////////////////////////////////////////////////////
	// control register

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			region_select <= RST_CONTROL[BIT_REGION_SELECT];
			voltage_detect_enable <= RST_CONTROL[BIT_DETECT_ENABLE];
			prog_pump_enable <= RST_CONTROL[BIT_PUMP_ENABLE];
			write_permit <= RST_CONTROL[BIT_WRITE_PERMIT];
			read_permit <= RST_CONTROL[BIT_READ_PERMIT];
		end else if (is_write(reg_write, reg_addr, OFS_ROM_ACCESS_CONTROL)) begin
			region_select <= reg_wdata[BIT_REGION_SELECT];
			voltage_detect_enable <= reg_wdata[BIT_DETECT_ENABLE];
			prog_pump_enable <= reg_wdata[BIT_PUMP_ENABLE];
			write_permit <= reg_wdata[BIT_WRITE_PERMIT];
			read_permit <= reg_wdata[BIT_READ_PERMIT];
		end
	end

	// analog outputs follow the enables directly
	assign prog_pump_on = prog_pump_enable;
	assign voltage_detect_on = voltage_detect_enable;
	assign display_supply_internal = display_pump_enable;

	////////////////////////////////////////////////////////////////
	// supply detector crossing

	// comparator output is asynchronous to the bus clock
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			supply_meta <= 1'b0;
			supply_sync <= 1'b0;
		end else begin
			supply_meta <= supply_above_threshold;
			supply_sync <= supply_meta;
		end
	end

	// flag is meaningless with detection off, so it reads low then
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prog_voltage_ok <= RST_CONTROL[BIT_VOLTAGE_OK];
		end else begin
			prog_voltage_ok <= voltage_detect_enable & supply_sync;
		end
	end

	////////////////////////////////////////////////////////////////
	// pointer and data registers

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rom_word_pointer <= {RST_POINTER_HIGH, RST_POINTER_LOW};
		end else if (is_write(reg_write, reg_addr, OFS_ROM_POINTER_HIGH)) begin
			rom_word_pointer[13:8] <= reg_wdata[5:0];
		end else if (is_write(reg_write, reg_addr, OFS_ROM_POINTER_LOW)) begin
			rom_word_pointer[7:0] <= reg_wdata;
		end
	end

	// a completed read overwrites both halves; it wins over a bus write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rom_word_value <= RST_WORD_VALUE;
		end else if (read_landing) begin
			rom_word_value <= store_word;
		end else if (is_write(reg_write, reg_addr, OFS_ROM_DATA_HIGH)) begin
			rom_word_value[15:8] <= reg_wdata;
		end else if (is_write(reg_write, reg_addr, OFS_ROM_DATA_LOW)) begin
			rom_word_value[7:0] <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// command decode

	assign mapped = map_pointer(region_select, rom_word_pointer, MAIN_IS_16K);
	assign in_range = mapped[INDEX_WIDTH];
	assign cmd_read = is_write(reg_write, reg_addr, OFS_ROM_COMMAND) && reg_wdata[BIT_CMD_READ];
	assign cmd_program = is_write(reg_write, reg_addr, OFS_ROM_COMMAND) && reg_wdata[BIT_CMD_PROGRAM];
	assign busy = (state != idle) || read_landing;

	// commands arriving while busy are dropped; program beats read if both
	assign start_program = cmd_program && !busy && in_range && write_permit && prog_voltage_ok;
	assign program_refused = cmd_program && !busy && in_range && !(write_permit && prog_voltage_ok);
	assign start_read = cmd_read && !cmd_program && !busy && in_range && read_permit;

	////////////////////////////////////////////////////////////////
	// access sequencer

	always_comb begin
		next_state = state;
		next_req = req;
		next_req.read_en = 1'b0;
		next_req.prog_en = 1'b0;
		case (state)
			idle: begin
				if (start_program) begin
					next_state = programming;
					next_req.prog_en = 1'b1;
					next_req.index = mapped[INDEX_WIDTH-1:0];
					next_req.word = rom_word_value;
				end else if (start_read) begin
					next_state = reading;
					next_req.read_en = 1'b1;
					next_req.index = mapped[INDEX_WIDTH-1:0];
				end
			end
			reading: begin
				next_state = idle;
			end
			programming: begin
				if (wait_count == WAIT_LAST) begin
					next_state = idle;
				end
			end
			default: begin
				next_state = idle;
			end
		endcase
	end

	// store word is out a cycle after the read request, so capture waits one more edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= idle;
			req <= '0;
			read_landing <= 1'b0;
		end else begin
			state <= next_state;
			req <= next_req;
			read_landing <= (state == reading);
		end
	end

	// the cell is written once at the start; the wait models the burn time
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wait_count <= '0;
		end else if (state == programming) begin
			wait_count <= wait_count + COUNT_WIDTH'(1);
		end else begin
			wait_count <= '0;
		end
	end

	assign program_pulse_on = (state == programming);

	////////////////////////////////////////////////////////////////
	// sticky error flags, a new event wins over a clear

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			refused <= 1'b0;
		end else if (program_refused) begin
			refused <= 1'b1;
		end else if (is_write(reg_write, reg_addr, OFS_ROM_COMMAND) && reg_wdata[BIT_STAT_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			range_error <= 1'b0;
		end else if ((cmd_read || cmd_program) && !busy && !in_range) begin
			range_error <= 1'b1;
		end else if (is_write(reg_write, reg_addr, OFS_ROM_COMMAND) && reg_wdata[BIT_STAT_RANGE]) begin
			range_error <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// word store

	otp_word_store u_store (
		.clock(clock),
		.rst_n(rst_n),
		.req(req),
		.read_word(store_word)
	);

	////////////////////////////////////////////////////////////////
	// read back, data one cycle after the strobe

	always_comb begin
		control_view = '0;
		control_view[BIT_CONTROL_ONE] = 1'b1;
		control_view[BIT_REGION_SELECT] = region_select;
		control_view[BIT_DETECT_ENABLE] = voltage_detect_enable;
		control_view[BIT_VOLTAGE_OK] = prog_voltage_ok;
		control_view[BIT_PUMP_ENABLE] = prog_pump_enable;
		control_view[BIT_WRITE_PERMIT] = write_permit;
		control_view[BIT_READ_PERMIT] = read_permit;
		status_view = '0;
		status_view[BIT_STAT_BUSY] = busy;
		status_view[BIT_STAT_REFUSED] = refused;
		status_view[BIT_STAT_RANGE] = range_error;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			case (reg_addr)
				OFS_ROM_ACCESS_CONTROL: reg_rdata <= control_view;
				OFS_ROM_POINTER_HIGH: reg_rdata <= {2'b00, rom_word_pointer[13:8]};
				OFS_ROM_POINTER_LOW: reg_rdata <= rom_word_pointer[7:0];
				OFS_ROM_DATA_HIGH: reg_rdata <= rom_word_value[15:8];
				OFS_ROM_DATA_LOW: reg_rdata <= rom_word_value[7:0];
				OFS_ROM_COMMAND: reg_rdata <= status_view;
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule : otp_data_region_access
`default_nettype wire

// File: rtl/otp_word_store.sv
`timescale 1ns/1ns
`default_nettype none
module otp_word_store (
	input wire logic clock,
	input wire logic rst_n,
	input wire otp_access_pkg::store_req_t req,
	output logic [15:0] read_word
);
	import otp_access_pkg::*;

	localparam int DEPTH = INFO_WORDS + MAIN_TAIL_WORDS;

	logic [15:0] cells [DEPTH];

	////////////////////////////////////////////////////////////////
	// cells start blank; programming can only clear bits, as in a fuse array
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				cells[i] <= BLANK_WORD;
			end
		end else if (req.prog_en) begin
			cells[req.index] <= cells[req.index] & req.word;
		end
	end

	// synchronous read, word stands the cycle after the request
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			read_word <= RST_WORD_VALUE;
		end else if (req.read_en) begin
			read_word <= cells[req.index];
		end
	end
endmodule : otp_word_store
`default_nettype wire

// File: verif/otp_access_sva.sv
`timescale 1ns/1ns
`default_nettype none
module otp_access_sva #(
	parameter int PROG_WAIT = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic supply_above_threshold,
	input wire logic display_pump_enable,
	input wire logic prog_pump_on,
	input wire logic voltage_detect_on,
	input wire logic program_pulse_on,
	input wire logic display_supply_internal
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic ctl_wr;
	logic permit;
	int pulse_len;
	assign ctl_wr = reg_write && reg_addr == 8'h2d;
	// mirror of write permit, since the bit is not a port
	always_ff @(posedge clock) begin
		if (!rst_n)
			permit <= 1'b0;
		else if (ctl_wr)
			permit <= reg_wdata[1];
	end
	// cycles the program pulse has stood so far
	always_ff @(posedge clock) begin
		if (!rst_n)
			pulse_len <= 0;
		else
			pulse_len <= program_pulse_on ? pulse_len + 1 : 0;
	end
	////////////////////////////////////////////////////////////////
	rdata_idle_a: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
		else $error("read data outside the answer cycle");
	pump_bit_a: assert property (ctl_wr |=> prog_pump_on == $past(reg_wdata[2]))
		else $error("pump enable does not follow control bit 2");
	detect_bit_a: assert property (ctl_wr |=> voltage_detect_on == $past(reg_wdata[4]))
		else $error("detect enable does not follow control bit 4");
	ctl_hold_a: assert property (!ctl_wr |=> $stable(prog_pump_on) && $stable(voltage_detect_on))
		else $error("control outputs moved without a write");
	disp_supply_a: assert property (display_supply_internal == display_pump_enable)
		else $error("display supply source wrong");
	prog_cause_a: assert property ($rose(program_pulse_on) |-> $past(reg_write && reg_addr == 8'h32 && reg_wdata[1]))
		else $error("program cycle without a command");
	prog_permit_a: assert property ($rose(program_pulse_on) |-> permit && voltage_detect_on)
		else $error("program cycle without permit or detection");
	prog_len_a: assert property ($fell(program_pulse_on) |-> pulse_len == PROG_WAIT)
		else $error("program cycle length wrong");
endmodule : otp_access_sva
bind otp_data_region_access otp_access_sva #(.PROG_WAIT(PROG_WAIT)) otp_access_sva_inst (.clock(clock),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .supply_above_threshold(supply_above_threshold),
	.display_pump_enable(display_pump_enable), .prog_pump_on(prog_pump_on),
	.voltage_detect_on(voltage_detect_on), .program_pulse_on(program_pulse_on),
	.display_supply_internal(display_supply_internal));
`default_nettype wire

// File: verif/supply_model.sv
`timescale 1ns/1ns
`default_nettype none
module supply_model #(
	parameter int RAMP = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic prog_pump_on,
	input wire logic ext_supply,
	output logic supply_above_threshold
);
	int ramp_cnt;
	// the pump needs time to charge up, an external supply is there at once
	always_ff @(posedge clock) begin
		if (!rst_n || !prog_pump_on)
			ramp_cnt <= 0;
		else if (ramp_cnt < RAMP)
			ramp_cnt <= ramp_cnt + 1;
	end
	assign supply_above_threshold = ext_supply || ramp_cnt == RAMP;
endmodule : supply_model
`default_nettype wire

// File: verif/tb_otp_data_region_access.sv
`timescale 1ns/1ns
`default_nettype none
module tb_otp_data_region_access;
	logic clock, rst_n, reg_write, reg_read, dpe, ext_supply, supply_ok;
	logic pump_on, detect_on, pulse_on, disp_int;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, b, s;
	logic [15:0] w, d, e;
	logic [15:0] mem [logic [14:0]];
	logic [13:0] p;
	int err_count, n_compared, cyc;
	// refusal and range cases: control, pointer, command, status
	logic [7:0] ctl_t [5] = '{8'h11, 8'h13, 8'h13, 8'h53, 8'h53};
	logic [13:0] ptr_t [5] = '{14'h0001, 14'h0001, 14'h0040, 14'h0005, 14'h3c00};
	logic [7:0] cmd_t [5] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h01};
	logic [7:0] st_t [5] = '{8'h10, 8'h10, 8'h20, 8'h20, 8'h20};
	otp_data_region_access #(.PROG_WAIT(8), .MAIN_IS_16K(1'b0)) otp_data_region_access_inst (.clock(clock),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .supply_above_threshold(supply_ok), .display_pump_enable(dpe),
		.prog_pump_on(pump_on), .voltage_detect_on(detect_on), .program_pulse_on(pulse_on),
		.display_supply_internal(disp_int));
	supply_model supply_model_inst (.clock(clock), .rst_n(rst_n), .prog_pump_on(pump_on),
		.ext_supply(ext_supply), .supply_above_threshold(supply_ok));
	always #25 clock = ~clock;
	// hang guard, far above the several hundred cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////
	task end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask : rd
	task getw();
		rd(8'h30, b);
		w[15:8] = b;
		rd(8'h31, b);
		w[7:0] = b;
	endtask : getw
	// clear flags, load everything, issue a command, poll until idle
	task op(input logic [7:0] ctl, input logic [13:0] ptr, input logic [15:0] v, input logic [7:0] c);
		wr(8'h32, 8'h30);
		wr(8'h2d, ctl);
		wr(8'h2e, {2'b00, ptr[13:8]});
		wr(8'h2f, ptr[7:0]);
		wr(8'h30, v[15:8]);
		wr(8'h31, v[7:0]);
		wr(8'h32, c);
		for (int i = 0; i < 20; i++) begin
			rd(8'h32, s);
			if (s[0] === 1'b0)
				break;
		end
	endtask : op
	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		dpe = 1'b0;
		ext_supply = 1'b0;
		void'($urandom(32'hfb7d808f));
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		// reset values, status and one unmapped place
		for (int i = 0; i < 7; i++) begin
			rd(8'h2d + 8'(i), b);
			chk({8'h00, b}, i == 0 ? 16'h0080 : 16'h0000);
		end
		wr(8'h2e, 8'hff);
		rd(8'h2e, b);
		chk({8'h00, b}, 16'h003f);
		d = 16'($urandom);
		wr(8'h30, d[15:8]);
		wr(8'h31, d[7:0]);
		dpe <= 1'b1;
		getw();
		chk(w, d);
		wr(8'h2d, 8'h54);
		rd(8'h2d, b);
		chk({8'h00, b}, 16'h00d4);
		chk({14'h0, pump_on, detect_on}, 16'h0003);
		chk({15'h0, disp_int}, 16'h0001);
		// pump has charged by now
		repeat (30) @(posedge clock);
		rd(8'h2d, b);
		chk({8'h00, b}, 16'h00dc);
		wr(8'h2d, 8'h40);
		dpe <= 1'b0;
		ext_supply <= 1'b1;
		rd(8'h2d, b);
		chk({8'h00, b}, 16'h00c0);
		chk({14'h0, pump_on, detect_on}, 16'h0000);
		chk({15'h0, disp_int}, 16'h0000);
		// few pointers near each region's top, so cells get programmed twice
		for (int k = 0; k < 8; k++) begin
			p = k[0] ? {4'h7, 10'h3fc | 10'($urandom % 4)} : 14'h003c | 14'($urandom % 4);
			d = 16'($urandom);
			op({1'b0, k[0], 6'h13}, p, d, 8'h02);
			e = mem.exists({k[0], p}) ? mem[{k[0], p}] & d : 16'hffff & d;
			mem[{k[0], p}] = e;
			op({1'b0, k[0], 6'h13}, p, 16'h0000, 8'h01);
			getw();
			chk(w, e);
		end
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			ext_supply <= (k != 1);
			op(ctl_t[k], ptr_t[k], 16'h0000, cmd_t[k]);
			chk({8'h00, s}, {8'h00, st_t[k]});
		end
		// refused programs left the cell blank
		op(8'h13, 14'h0001, 16'h0000, 8'h01);
		getw();
		chk(w, 16'hffff);
		// without read permit the data registers keep what was written
		op(8'h12, 14'h003c, 16'h1234, 8'h01);
		getw();
		chk(w, 16'h1234);
		end_sim();
	end
endmodule : tb_otp_data_region_access
`default_nettype wire
